// ==== fbsd_decoder_sva.sv ====
/*
 * fbsd_decoder_sva: concurrent checks on the ports of the decoder top.
 * Assumes the one ref_clk domain with reset_n asynchronous, active low.
 */
`timescale 1ns/1ps
module fbsd_decoder_sva (
    // clock and reset
    input wire logic                              ref_clk,
    input wire logic                              reset_n,
    // read side
    input wire logic                              rd_req,
    input wire logic [fbsd_pkg::ADDR_W-1:0]       rd_addr,
    input wire logic                              rd_done,
    input wire logic [fbsd_pkg::NUM_SECT-1:0]     rd_sector_sel,
    input wire logic [fbsd_pkg::SECT_IDX_W-1:0]   rd_sector_idx,
    input wire logic [fbsd_pkg::BANK_W-1:0]       rd_bank,
    input wire logic                              rd_lower_module,
    input wire logic                              rd_upper_module,
    input wire logic                              rd_ibus_sel,
    input wire logic                              rd_ctrl_space,
    input wire logic                              rd_unmapped,
    input wire logic                              rd_bank_conflict,
    // program/erase side
    input wire logic                              pe_start,
    input wire logic [fbsd_pkg::ADDR_W-1:0]       pe_addr,
    input wire logic                              pe_done,
    input wire logic                              pe_accept,
    input wire logic                              pe_reject,
    input wire logic [fbsd_pkg::SECT_IDX_W-1:0]   pe_sector_idx,
    input wire logic [fbsd_pkg::BANK_W-1:0]       pe_bank,
    input wire logic                              pe_active,
    input wire logic [fbsd_pkg::NUM_BANK-1:0]     bank_busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    chk_rd_done_pulse: assert property (1'b1 |=> rd_done == $past(rd_req))
        else $error("read answer not one cycle after request");
    chk_rd_big_sector: assert property (rd_req && rd_addr inside {[24'h01_8000:24'h01_ffff]}
        |=> rd_sector_idx == 5'h04 && rd_bank == 2'h0 && rd_lower_module)
        else $error("32 KB sector decoded wrongly");
    chk_rd_gap_flag: assert property (rd_req && rd_addr inside {[24'h00_8000:24'h01_7fff]}
        |=> rd_unmapped && rd_sector_sel == '0 && !rd_ibus_sel)
        else $error("gap address selected a sector");
    chk_rd_ctrl_space: assert property (rd_req && rd_addr inside {[24'h0e_0000:24'h0e_ffff]}
        |=> rd_ctrl_space && rd_sector_sel == '0 && !rd_upper_module)
        else $error("service space decoded as array");
    chk_rd_upper_range: assert property (rd_req && rd_addr inside
        {[24'h09_0000:24'h0d_ffff]} |=> rd_upper_module && !rd_lower_module && !rd_ibus_sel)
        else $error("upper module range decoded wrongly");
    chk_rd_conflict_bank: assert property (rd_req |=> rd_bank_conflict ==
        (|rd_sector_sel && |($past(bank_busy) & (4'h1 << rd_bank))))
        else $error("conflict flag disagrees with busy bank");
    chk_sel_onehot: assert property ($onehot0(rd_sector_sel) && $onehot0(bank_busy))
        else $error("sector or busy vector not one-hot");
    chk_pe_low_reject: assert property (pe_start && pe_addr < 24'h01_0000 |=> pe_reject && !pe_accept)
        else $error("program/erase at low segment not refused");
    chk_pe_remap_view: assert property (pe_start && !pe_active && pe_addr inside
        {[24'h01_0000:24'h01_7fff]} |=> pe_accept && pe_bank == 2'h0
        && pe_sector_idx == {3'h0, $past(pe_addr[14:13])})
        else $error("relocated small sector decoded wrongly");
    chk_pe_one_op: assert property (pe_start && pe_active |=> pe_reject && !pe_accept)
        else $error("second operation accepted while busy");
    chk_pe_done_clear: assert property (pe_done && pe_active |=> !pe_active && bank_busy == 4'h0)
        else $error("operation end did not clear busy");
    chk_busy_bank_match: assert property (pe_accept |-> pe_active && bank_busy == (4'h1 << pe_bank))
        else $error("busy bank differs from accepted bank");
endmodule : fbsd_decoder_sva

bind fbsd_flash_bank_sector_decoder fbsd_decoder_sva fbsd_decoder_sva_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_done(rd_done), .rd_sector_sel(rd_sector_sel), .rd_sector_idx(rd_sector_idx),
    .rd_bank(rd_bank), .rd_lower_module(rd_lower_module), .rd_upper_module(rd_upper_module),
    .rd_ibus_sel(rd_ibus_sel), .rd_ctrl_space(rd_ctrl_space), .rd_unmapped(rd_unmapped),
    .rd_bank_conflict(rd_bank_conflict), .pe_start(pe_start), .pe_addr(pe_addr),
    .pe_done(pe_done), .pe_accept(pe_accept), .pe_reject(pe_reject),
    .pe_sector_idx(pe_sector_idx), .pe_bank(pe_bank), .pe_active(pe_active),
    .bank_busy(bank_busy));

// ==== fbsd_flash_bank_sector_decoder.sv ====
/*
 * fbsd_flash_bank_sector_decoder: address decoding and bank organisation
 * for an on-chip nonvolatile memory of two modules and four banks.
 * Read requests from the core are decoded to module, bank, sector and
 * bus; program/erase requests from the single program/erase controller
 * are decoded in the relocated view and mark their bank busy.
 * Assumes both request ports are driven by logic on ref_clk.
 */
// Overview of operation
// - Two modules of two banks each, and a read of one bank is served while another bank is modified.
// - Every program and erase on any bank goes through the one program/erase controller.
// - The lower 512 Kbytes go over the 32-bit internal bus and the upper 320 Kbytes over the 16-bit peripheral bus.
// - Addresses 0x00_0000 to 0x08_ffff belong to the lower module (512 Kbyte).
// - Addresses 0x09_0000 to 0x0d_ffff belong to the upper module (320 Kbyte).
// - Addresses 0x0e_0000 to 0x0e_ffff are control and service space, never array sectors.
// - Bank 0 holds 384 Kbyte in 10 sectors plus a reserved test sector outside the sector map.
// - Read view: bank 0 sectors 0 to 3 are 8 KB each from 0x00_0000 to 0x00_7fff.
// - Read view: bank 0 sector 4 is 32 KB at 0x01_8000 to 0x01_ffff.
// - Read view: bank 0 sectors 5 to 9 are 64 KB each from 0x02_0000 to 0x06_ffff.
// - Bank 1 holds two 64 KB sectors read at 0x07_0000 and 0x08_0000.
// - Bank 2 holds three 64 KB sectors read at 0x09_0000, 0x0a_0000 and 0x0b_0000.
// - Bank 3 holds two 64 KB sectors read at 0x0c_0000 and 0x0d_0000 over the 16-bit bus.
// - For program or erase the four 8 KB bank 0 sectors are relocated into code segment 1, as the segment remap bit does.
`timescale 1ns/1ps
module fbsd_flash_bank_sector_decoder (
    // clock and reset
    input  wire logic                                ref_clk,
    input  wire logic                                reset_n,
    // core read request
    input  wire logic                                rd_req,
    input  wire logic [fbsd_pkg::ADDR_W-1:0]         rd_addr,
    // read decode result
    output logic                                     rd_done,
    output logic [fbsd_pkg::NUM_SECT-1:0]            rd_sector_sel,
    output logic [fbsd_pkg::SECT_IDX_W-1:0]          rd_sector_idx,
    output logic [fbsd_pkg::BANK_W-1:0]              rd_bank,
    output logic                                     rd_lower_module,
    output logic                                     rd_upper_module,
    output logic                                     rd_ibus_sel,
    output logic                                     rd_xbus_sel,
    output logic                                     rd_ctrl_space,
    output logic                                     rd_unmapped,
    output logic                                     rd_outside,
    output logic                                     rd_bank_conflict,
    // program/erase controller request
    input  wire logic                                pe_start,
    input  wire logic [fbsd_pkg::ADDR_W-1:0]         pe_addr,
    input  wire logic                                pe_done,
    // program/erase decode result and bank state
    output logic                                     pe_accept,
    output logic                                     pe_reject,
    output logic [fbsd_pkg::NUM_SECT-1:0]            pe_sector_sel,
    output logic [fbsd_pkg::SECT_IDX_W-1:0]          pe_sector_idx,
    output logic [fbsd_pkg::BANK_W-1:0]              pe_bank,
    output logic                                     pe_active,
    output logic [fbsd_pkg::NUM_BANK-1:0]            bank_busy
);

    // combinational decode results
    logic [fbsd_pkg::NUM_SECT-1:0]   rd_hit;
    logic [fbsd_pkg::NUM_SECT-1:0]   pe_hit;
    logic [fbsd_pkg::SECT_IDX_W-1:0] rd_idx;
    logic [fbsd_pkg::SECT_IDX_W-1:0] pe_idx;
    logic                            rd_any;
    logic                            pe_any;
    logic                            rd_in_lower;
    logic                            rd_in_upper;
    logic                            rd_in_ctrl;
    logic [fbsd_pkg::BANK_W-1:0]     rd_bank_d;
    logic [fbsd_pkg::BANK_W-1:0]     pe_bank_d;
    logic                            rd_blocked;

    // registered state
    fbsd_pkg::fbsd_pe_state_t        pe_state_q;
    fbsd_pkg::fbsd_pe_state_t        pe_state_d;
    logic                            rd_done_q;
    logic [fbsd_pkg::NUM_SECT-1:0]   rd_sel_q;
    logic [fbsd_pkg::SECT_IDX_W-1:0] rd_idx_q;
    logic [fbsd_pkg::BANK_W-1:0]     rd_bank_q;
    logic                            rd_lower_q;
    logic                            rd_upper_q;
    logic                            rd_ibus_q;
    logic                            rd_xbus_q;
    logic                            rd_ctrl_q;
    logic                            rd_unmapped_q;
    logic                            rd_outside_q;
    logic                            rd_conflict_q;
    logic                            pe_accept_q;
    logic                            pe_reject_q;
    logic [fbsd_pkg::NUM_SECT-1:0]   pe_sel_q;
    logic [fbsd_pkg::SECT_IDX_W-1:0] pe_idx_q;
    logic [fbsd_pkg::BANK_W-1:0]     pe_bank_q;
    logic [fbsd_pkg::NUM_BANK-1:0]   busy_q;

    // module region decode on the read address
    // lower module range
    fbsd_range_hit #(
        .BASE (fbsd_pkg::LOWER_BASE),
        .LAST (fbsd_pkg::LOWER_LAST)
    ) u_rd_lower (
        .addr (rd_addr),
        .hit  (rd_in_lower)
    );

    fbsd_range_hit #(
        .BASE (fbsd_pkg::UPPER_BASE),
        .LAST (fbsd_pkg::UPPER_LAST)
    ) u_rd_upper (
        .addr (rd_addr),
        .hit  (rd_in_upper)
    );

    fbsd_range_hit #(
        .BASE (fbsd_pkg::CTRL_BASE),
        .LAST (fbsd_pkg::CTRL_LAST)
    ) u_rd_ctrl (
        .addr (rd_addr),
        .hit  (rd_in_ctrl)
    );

    // sector matchers, one per sector for each view; the test sector
    // has no entry, so it is never reachable through this decoder
    // all seventeen sectors of the four banks
    for (genvar s = 0; s < fbsd_pkg::NUM_SECT; s++) begin : g_sect
        localparam fbsd_pkg::fbsd_addr_t PE_OFS =
            (s < fbsd_pkg::NUM_REMAP) ? fbsd_pkg::REMAP_OFFSET : '0;

        fbsd_range_hit #(
            .BASE (fbsd_pkg::RD_BASE[s]),
            .LAST (fbsd_pkg::RD_LAST[s])
        ) u_rd (
            .addr (rd_addr),
            .hit  (rd_hit[s])
        );

        fbsd_range_hit #(
            .BASE (fbsd_pkg::RD_BASE[s] + PE_OFS),
            .LAST (fbsd_pkg::RD_LAST[s] + PE_OFS)
        ) u_pe (
            .addr (pe_addr),
            .hit  (pe_hit[s])
        );
    end

    // sector index encoders for both views
    fbsd_onehot_idx #(
        .W  (fbsd_pkg::NUM_SECT),
        .IW (fbsd_pkg::SECT_IDX_W)
    ) u_rd_idx (
        .sel (rd_hit),
        .idx (rd_idx),
        .any (rd_any)
    );

    fbsd_onehot_idx #(
        .W  (fbsd_pkg::NUM_SECT),
        .IW (fbsd_pkg::SECT_IDX_W)
    ) u_pe_idx (
        .sel (pe_hit),
        .idx (pe_idx),
        .any (pe_any)
    );

    // bank lookup from the sector index; zero when nothing hits
    assign rd_bank_d = rd_any ? fbsd_pkg::SECT_BANK[rd_idx] : fbsd_pkg::BANK_RST;
    assign pe_bank_d = pe_any ? fbsd_pkg::SECT_BANK[pe_idx] : fbsd_pkg::BANK_RST;

    // block only the bank under modification
    assign rd_blocked = rd_any && busy_q[rd_bank_d];

    // read result: a pulse marks each decoded request, the fields hold
    // until the next request so the bus side may sample them late
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_done_q <= 1'b0;
        end else begin
            rd_done_q <= rd_req;
        end
    end

    // read field capture
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_sel_q      <= fbsd_pkg::SECT_SEL_RST;
            rd_idx_q      <= fbsd_pkg::SECT_IDX_RST;
            rd_bank_q     <= fbsd_pkg::BANK_RST;
            rd_lower_q    <= 1'b0;
            rd_upper_q    <= 1'b0;
            rd_ctrl_q     <= 1'b0;
            rd_outside_q  <= 1'b0;
            rd_unmapped_q <= 1'b0;
            rd_conflict_q <= 1'b0;
        end else if (rd_req) begin
            rd_sel_q      <= rd_hit;
            rd_idx_q      <= rd_idx;
            rd_bank_q     <= rd_bank_d;
            rd_lower_q    <= rd_in_lower;
            rd_upper_q    <= rd_in_upper;
            rd_ctrl_q     <= rd_in_ctrl;
            rd_outside_q  <= !(rd_in_lower || rd_in_upper || rd_in_ctrl);
            rd_unmapped_q <= (rd_in_lower || rd_in_upper) && !rd_any;
            rd_conflict_q <= rd_blocked;
        end
    end

    // bus routing; a blocked or unmapped read drives neither bus
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ibus_q <= 1'b0;
            rd_xbus_q <= 1'b0;
        end else if (rd_req) begin
            rd_ibus_q <= rd_any && rd_in_lower && !rd_blocked;
            rd_xbus_q <= rd_any && rd_in_upper && !rd_blocked;
        end
    end

    // program/erase sequencing: one operation at a time, since there is
    // only one controller to carry it; a second start is refused
    // single controller
    always_comb begin
        pe_state_d = pe_state_q;
        case (pe_state_q)
            fbsd_pkg::FBSD_PE_IDLE: begin
                if (pe_start && pe_any) begin
                    pe_state_d = fbsd_pkg::FBSD_PE_BUSY;
                end
            end
            fbsd_pkg::FBSD_PE_BUSY: begin
                if (pe_done) begin
                    pe_state_d = fbsd_pkg::FBSD_PE_IDLE;
                end
            end
            default: begin
                pe_state_d = fbsd_pkg::FBSD_PE_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pe_state_q <= fbsd_pkg::FBSD_PE_IDLE;
        end else begin
            pe_state_q <= pe_state_d;
        end
    end

    // answers to the controller, one-cycle pulses
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pe_accept_q <= 1'b0;
            pe_reject_q <= 1'b0;
        end else begin
            pe_accept_q <= pe_start && pe_any && (pe_state_q == fbsd_pkg::FBSD_PE_IDLE);
            pe_reject_q <= pe_start && !(pe_any && (pe_state_q == fbsd_pkg::FBSD_PE_IDLE));
        end
    end

    // target of the accepted operation, held while it runs
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pe_sel_q  <= fbsd_pkg::SECT_SEL_RST;
            pe_idx_q  <= fbsd_pkg::SECT_IDX_RST;
            pe_bank_q <= fbsd_pkg::BANK_RST;
        end else if (pe_start && pe_any && (pe_state_q == fbsd_pkg::FBSD_PE_IDLE)) begin
            pe_sel_q  <= pe_hit;
            pe_idx_q  <= pe_idx;
            pe_bank_q <= pe_bank_d;
        end
    end

    // busy bank map follows the state machine, so it is cleared by done
    // and set by an accepted start; the two cannot meet in one cycle
    // mark modified bank
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= fbsd_pkg::BUSY_RST;
        end else if (pe_state_q == fbsd_pkg::FBSD_PE_IDLE) begin
            if (pe_start && pe_any) begin
                busy_q <= fbsd_pkg::NUM_BANK'(1) << pe_bank_d;
            end
        end else if (pe_done) begin
            busy_q <= fbsd_pkg::BUSY_RST;
        end
    end

    // outputs straight from flip-flops
    assign rd_done          = rd_done_q;
    assign rd_sector_sel    = rd_sel_q;
    assign rd_sector_idx    = rd_idx_q;
    assign rd_bank          = rd_bank_q;
    assign rd_lower_module  = rd_lower_q;
    assign rd_upper_module  = rd_upper_q;
    assign rd_ibus_sel      = rd_ibus_q;
    assign rd_xbus_sel      = rd_xbus_q;
    assign rd_ctrl_space    = rd_ctrl_q;
    assign rd_unmapped      = rd_unmapped_q;
    assign rd_outside       = rd_outside_q;
    assign rd_bank_conflict = rd_conflict_q;
    assign pe_accept        = pe_accept_q;
    assign pe_reject        = pe_reject_q;
    assign pe_sector_sel    = pe_sel_q;
    assign pe_sector_idx    = pe_idx_q;
    assign pe_bank          = pe_bank_q;
    assign pe_active        = pe_state_q[1];
    assign bank_busy        = busy_q;

endmodule : fbsd_flash_bank_sector_decoder

// ==== fbsd_flash_bank_sector_decoder_bench.sv ====
/*
 * fbsd_flash_bank_sector_decoder_bench: self-checking bench of the decoder.
 * Assumes the package, the decoder, its checker and the controller model.
 */
`timescale 1ns/1ps
module fbsd_flash_bank_sector_decoder_bench;
    localparam fbsd_pkg::fbsd_addr_t TBL [22] = '{
        24'h00_0000, 24'h00_1fff, 24'h00_2000, 24'h00_7fff, 24'h00_8000, 24'h00_ffff,
        24'h01_0000, 24'h01_7fff, 24'h01_8000, 24'h01_ffff, 24'h02_0000, 24'h06_ffff,
        24'h07_0000, 24'h08_ffff, 24'h09_0000, 24'h0b_ffff, 24'h0c_0000, 24'h0d_ffff,
        24'h0e_0000, 24'h0e_ffff, 24'h0f_0000, 24'hff_ffff};
    logic                 ref_clk = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 rd_req = 1'b0;
    fbsd_pkg::fbsd_addr_t rd_addr = '0;
    logic                 cmd_go = 1'b0;
    fbsd_pkg::fbsd_addr_t cmd_addr = '0;
    logic [7:0]           cmd_len = '0;
    logic                 pe_start;
    logic                 pe_done;
    fbsd_pkg::fbsd_addr_t pe_addr;
    wire [32:0]           got_rd;
    wire [30:0]           got_pe;
    logic [32:0]          e_rd = '0;
    logic [30:0]          e_pe = '0;
    logic [31:0]          seed = 32'h67e2;
    logic                 m_act;
    int                   m_i;
    int                   fails = 0;
    int                   check_count = 0;

    fbsd_flash_bank_sector_decoder fbsd_flash_bank_sector_decoder_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_done(got_rd[32]), .rd_sector_sel(got_rd[31:15]), .rd_sector_idx(got_rd[14:10]),
        .rd_bank(got_rd[9:8]), .rd_lower_module(got_rd[7]), .rd_upper_module(got_rd[6]),
        .rd_ibus_sel(got_rd[5]), .rd_xbus_sel(got_rd[4]), .rd_ctrl_space(got_rd[3]),
        .rd_unmapped(got_rd[2]), .rd_outside(got_rd[1]), .rd_bank_conflict(got_rd[0]),
        .pe_start(pe_start), .pe_addr(pe_addr), .pe_done(pe_done),
        .pe_accept(got_pe[30]), .pe_reject(got_pe[29]), .pe_sector_sel(got_pe[28:12]),
        .pe_sector_idx(got_pe[11:7]), .pe_bank(got_pe[6:5]), .pe_active(got_pe[4]),
        .bank_busy(got_pe[3:0]));

    fbsd_pe_ctrl_model fbsd_pe_ctrl_model_i (
        .ref_clk(ref_clk), .cmd_go(cmd_go), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
        .pe_start(pe_start), .pe_addr(pe_addr), .pe_done(pe_done));

    // 50 MHz
    always #10 ref_clk = ~ref_clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // half the picks land on boundaries, where slips show
    function automatic fbsd_pkg::fbsd_addr_t pick();
        logic [31:0] r;
        r = rnd();
        return r[0] ? TBL[(r >> 4) % 22] : (r[1] ? r[31:8] : {4'h0, r[27:8]});
    endfunction : pick

    // sector index, read or relocated view, -1 for none
    function automatic int sidx(input int a, input bit pe);
        if (pe && a < 'h1_0000) return -1;
        if (pe && a < 'h1_8000) return (a - 'h1_0000) >> 13;
        if (!pe && a < 'h8000) return a >> 13;
        if (a >= 'h1_8000 && a < 'h2_0000) return 4;
        if (a >= 'h2_0000 && a < 'he_0000) return (a >> 16) + 3;
        return -1;
    endfunction : sidx

    function automatic logic [1:0] bk(input int i);
        return (i < 10) ? 2'h0 : (i < 12) ? 2'h1 : (i < 15) ? 2'h2 : 2'h3;
    endfunction : bk

    function automatic logic [32:0] rd_exp(input int a, input logic [3:0] busy);
        int i;
        logic h, lo, up, cf;
        logic [1:0] b;
        i = sidx(a, 1'b0);
        h = i >= 0;
        b = h ? bk(i) : 2'h0;
        lo = a <= 'h8_ffff;
        up = a >= 'h9_0000 && a <= 'hd_ffff;
        cf = h && busy[b];
        return {1'b1, h ? 17'h1 << i : 17'h0, h ? i[4:0] : 5'h0, b, lo, up, lo && h && !cf,
                up && h && !cf, a >= 'he_0000 && a <= 'he_ffff, (lo || up) && !h, a > 'he_ffff, cf};
    endfunction : rd_exp

    // reference model; reads see the old busy state
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            e_rd = '0;
            e_pe = '0;
        end else begin
            m_act = e_pe[4];
            if (rd_req) e_rd = rd_exp(rd_addr, e_pe[3:0]);
            else e_rd[32] = 1'b0;
            e_pe[30:29] = 2'b00;
            if (pe_done && m_act) e_pe[4:0] = 5'h00;
            m_i = sidx(pe_addr, 1'b1);
            if (pe_start && !m_act && m_i >= 0)
                e_pe = {2'b10, 17'h1 << m_i, m_i[4:0], bk(m_i), 1'b1, 4'h1 << bk(m_i)};
            else if (pe_start) e_pe[29] = 1'b1;
        end
    end

    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    always @(negedge ref_clk) begin
        chk(got_rd, e_rd);
        chk({2'b00, got_pe}, {2'b00, e_pe});
    end

    task automatic run(input int n);
        logic [31:0] r;
        repeat (n) begin
            @(negedge ref_clk);
            r = rnd();
            rd_req <= r[0] | r[1];
            rd_addr <= pick();
            cmd_go <= r[7:4] == 4'h0;
            cmd_addr <= pick();
            cmd_len <= {2'b00, r[13:8]} + 8'h01;
        end
    endtask : run

    task automatic close_out();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    initial begin
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        reset_n <= 1'b1;
        // bank 2 busy while the boundary table is read back to back
        cmd_go <= 1'b1;
        cmd_addr <= 24'h09_0000;
        cmd_len <= 8'h30;
        foreach (TBL[k]) begin
            @(negedge ref_clk);
            cmd_go <= 1'b0;
            rd_req <= 1'b1;
            rd_addr <= TBL[k];
        end
        run(3000);
        // reset again in mid-run
        @(negedge ref_clk);
        reset_n <= 1'b0;
        @(negedge ref_clk);
        reset_n <= 1'b1;
        run(400);
        repeat (2) @(negedge ref_clk);
        close_out();
    end

    // watchdog, far past the 3400-cycle run
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        close_out();
    end
endmodule : fbsd_flash_bank_sector_decoder_bench

// ==== fbsd_onehot_idx.sv ====
/*
 * fbsd_onehot_idx: turns a one-hot select vector into its index.
 * Combinational; an all-zero vector gives index zero and any low.
 */
`timescale 1ns/1ps
module fbsd_onehot_idx #(
    parameter int W  = 17,
    parameter int IW = 5
) (
    // one-hot input
    input  wire logic [W-1:0]  sel,
    // encoded result
    output logic [IW-1:0]      idx,
    output logic               any
);

    // or-reduce the positions; a legal one-hot vector has one bit set
    always_comb begin
        idx = '0;
        for (int i = 0; i < W; i++) begin
            if (sel[i]) begin
                idx = idx | IW'(i);
            end
        end
        any = |sel;
    end

endmodule : fbsd_onehot_idx

// ==== fbsd_pe_ctrl_model.sv ====
/*
 * fbsd_pe_ctrl_model: behavioural program/erase controller on the far side.
 * Assumes commands from the bench; drives its lines at the falling edge.
 */
`timescale 1ns/1ps
module fbsd_pe_ctrl_model (
    // clock and command from the bench
    input wire logic                          ref_clk,
    input wire logic                          cmd_go,
    input wire logic [fbsd_pkg::ADDR_W-1:0]   cmd_addr,
    input wire logic [7:0]                    cmd_len,
    // lines toward the decoder
    output logic                              pe_start,
    output logic [fbsd_pkg::ADDR_W-1:0]       pe_addr,
    output logic                              pe_done
);
    logic [7:0] cnt_q = 8'h00;

    initial begin
        pe_start = 1'b0;
        pe_addr = 24'h00_0000;
        pe_done = 1'b0;
    end

    // single controller sequencing
    // address toggles when idle, so stale values show up
    always @(negedge ref_clk) begin
        pe_start <= cmd_go;
        pe_addr <= cmd_go ? cmd_addr : ~pe_addr;
        cnt_q <= cmd_go ? cmd_len : (cnt_q != 8'h00 ? cnt_q - 8'h01 : 8'h00);
        pe_done <= cnt_q == 8'h01;
    end
endmodule : fbsd_pe_ctrl_model

// ==== fbsd_pkg.sv ====
/*
 * fbsd_pkg: shared constants for the flash bank and sector decoder.
 * Holds address widths, module regions, the read-mode sector table,
 * the program/erase relocation and the reset values of the outputs.
 * Assumes byte addresses of 24 bits coming from the core and the
 * program/erase controller, all on the one system clock.
 */
package fbsd_pkg;

    localparam int ADDR_W     = 24;
    localparam int NUM_SECT   = 17;
    localparam int NUM_BANK   = 4;
    localparam int SECT_IDX_W = 5;
    localparam int BANK_W     = 2;

    typedef logic [ADDR_W-1:0] fbsd_addr_t;
    typedef logic [BANK_W-1:0] fbsd_bank_t;

    // module regions and the service space above them
    localparam fbsd_addr_t LOWER_BASE = 24'h00_0000;
    localparam fbsd_addr_t LOWER_LAST = 24'h08_ffff;
    localparam fbsd_addr_t UPPER_BASE = 24'h09_0000;
    localparam fbsd_addr_t UPPER_LAST = 24'h0d_ffff;
    localparam fbsd_addr_t CTRL_BASE  = 24'h0e_0000;
    localparam fbsd_addr_t CTRL_LAST  = 24'h0e_ffff;

    // program/erase view: the small low sectors move up into code segment 1
    localparam fbsd_addr_t REMAP_OFFSET = 24'h01_0000;
    localparam int         NUM_REMAP    = 4;

    // read-mode sector table, index = bank 0 sectors 0..9, then banks 1..3
    localparam fbsd_addr_t RD_BASE [NUM_SECT] = '{
        24'h00_0000, 24'h00_2000, 24'h00_4000, 24'h00_6000, 24'h01_8000,
        24'h02_0000, 24'h03_0000, 24'h04_0000, 24'h05_0000, 24'h06_0000,
        24'h07_0000, 24'h08_0000,
        24'h09_0000, 24'h0a_0000, 24'h0b_0000,
        24'h0c_0000, 24'h0d_0000};
    localparam fbsd_addr_t RD_LAST [NUM_SECT] = '{
        24'h00_1fff, 24'h00_3fff, 24'h00_5fff, 24'h00_7fff, 24'h01_ffff,
        24'h02_ffff, 24'h03_ffff, 24'h04_ffff, 24'h05_ffff, 24'h06_ffff,
        24'h07_ffff, 24'h08_ffff,
        24'h09_ffff, 24'h0a_ffff, 24'h0b_ffff,
        24'h0c_ffff, 24'h0d_ffff};
    localparam fbsd_bank_t SECT_BANK [NUM_SECT] = '{
        2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h1, 2'h1,
        2'h2, 2'h2, 2'h2,
        2'h3, 2'h3};

    // reset values
    localparam logic [NUM_SECT-1:0]   SECT_SEL_RST = 17'h0_0000;
    localparam logic [SECT_IDX_W-1:0] SECT_IDX_RST = 5'h00;
    localparam fbsd_bank_t            BANK_RST     = 2'h0;
    localparam logic [NUM_BANK-1:0]   BUSY_RST     = 4'h0;

    // program/erase controller states, one-hot
    typedef enum logic [1:0] {
        FBSD_PE_IDLE = 2'b01,
        FBSD_PE_BUSY = 2'b10
    } fbsd_pe_state_t;

endpackage : fbsd_pkg

// ==== fbsd_range_hit.sv ====
/*
 * fbsd_range_hit: tells whether an address falls in one inclusive range.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module fbsd_range_hit #(
    parameter fbsd_pkg::fbsd_addr_t BASE = 24'h00_0000,
    parameter fbsd_pkg::fbsd_addr_t LAST = 24'h00_0000
) (
    // address under test
    input  wire logic [fbsd_pkg::ADDR_W-1:0] addr,
    // result
    output logic                             hit
);

    // inclusive bounds on both ends
    assign hit = (addr >= BASE) && (addr <= LAST);

endmodule : fbsd_range_hit
